//--- tlc_regs.sv
// two-wire bus slave with loop pacing, main configuration and lock logic
`timescale 1ns/1ps
`include "tlc_defs.svh"

module tlc_regs #(
  parameter logic [6:0] SLAVE_ADDR = `TLC_SLAVE_ADDR,
  parameter int MON_CYCLE_CLKS = (`TLC_MON_CYCLE_MS * `TLC_NS_PER_MS) / `TLC_CLK_PERIOD_NS,
  parameter int TIMEOUT_CLKS = (`TLC_BUS_TIMEOUT_MS * `TLC_NS_PER_MS) / `TLC_CLK_PERIOD_NS,
  parameter int CHANNELS = 3
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic power_good_in,
  input wire logic [CHANNELS-1:0] adjust_done_in,
  output logic [CHANNELS-1:0] decrease_ok_out,
  output logic [CHANNELS-1:0] increase_ok_out,
  output logic monitor_start_bit_out,
  output logic all_fans_full_speed_out,
  output logic spinup_pulse_disable_out,
  output logic bus_timeout_disable_out,
  output logic supply_5v_scale_out,
  output logic power_display_out,
  output logic config_locked_out
);
  tlc_pkg::tlc_state_t state;
  logic scl_prev;
  logic sda_prev;
  logic [3:0] bit_cnt;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic [7:0] pointer;
  logic is_read;
  logic nacked;
  logic [31:0] low_cnt;
  logic [31:0] mon_cnt;
  logic mon_tick;
  logic [7:0] loop_pacing_control_one;
  logic [7:0] loop_pacing_control_two;
  logic [7:0] main_configuration_one;
  logic wr_pulse;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic bus_timeout;
  logic locked;
  logic [2:0] pacing_code [CHANNELS];
  logic dyn_enable [CHANNELS];

  assign scl_rise = scl_in & ~scl_prev;
  assign scl_fall = ~scl_in & scl_prev;
  assign bus_start = scl_in & scl_prev & sda_prev & ~sda_in;
  assign bus_stop = scl_in & scl_prev & ~sda_prev & sda_in;
  assign locked = main_configuration_one[`TLC_CFG_LOCK];
  // clock-stretch hosts that cannot take a timeout set the disable bit
  assign bus_timeout = ~main_configuration_one[`TLC_CFG_TIMEOUT_DIS]
    && (low_cnt >= 32'(TIMEOUT_CLKS));

  // open drain: the pin only ever pulls low
  assign sda_out = 1'b0;

  always_comb begin
    if (pointer == `TLC_OFS_LOOP_ONE) begin
      rd_data = loop_pacing_control_one;
    end else if (pointer == `TLC_OFS_LOOP_TWO) begin
      rd_data = loop_pacing_control_two;
    end else if (pointer == `TLC_OFS_CONFIG) begin
      rd_data = main_configuration_one;
    end else begin
      rd_data = `TLC_READ_UNMAPPED;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_in;
      sda_prev <= sda_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_cnt <= 32'h0000_0000;
    end else if (scl_in || state == tlc_pkg::TLC_IDLE) begin
      low_cnt <= 32'h0000_0000;
    end else if (low_cnt < 32'(TIMEOUT_CLKS)) begin
      low_cnt <= low_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= tlc_pkg::TLC_IDLE;
      bit_cnt <= 4'h0;
      rx_byte <= 8'h00;
      tx_byte <= 8'h00;
      pointer <= 8'h00;
      is_read <= 1'b0;
      nacked <= 1'b0;
      sda_oe_out <= 1'b0;
      wr_pulse <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_pulse <= 1'b0;
      if (bus_stop || bus_timeout) begin
        state <= tlc_pkg::TLC_IDLE;
        sda_oe_out <= 1'b0;
      end else if (bus_start) begin
        state <= tlc_pkg::TLC_ADDR;
        bit_cnt <= 4'h0;
        sda_oe_out <= 1'b0;
      end else begin
        case (state)
          tlc_pkg::TLC_ADDR, tlc_pkg::TLC_CMD, tlc_pkg::TLC_WDATA: begin
            if (scl_rise) begin
              rx_byte <= {rx_byte[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `TLC_BITS_PER_BYTE) begin
              bit_cnt <= 4'h0;
              if (state == tlc_pkg::TLC_ADDR) begin
                if (rx_byte[7:1] == SLAVE_ADDR) begin
                  sda_oe_out <= 1'b1;
                  is_read <= rx_byte[0];
                  state <= tlc_pkg::TLC_ACK_ADDR;
                end else begin
                  state <= tlc_pkg::TLC_IDLE;
                end
              end else if (state == tlc_pkg::TLC_CMD) begin
                pointer <= rx_byte;
                sda_oe_out <= 1'b1;
                state <= tlc_pkg::TLC_ACK_CMD;
              end else begin
                wr_pulse <= 1'b1;
                wr_data <= rx_byte;
                sda_oe_out <= 1'b1;
                state <= tlc_pkg::TLC_ACK_WDATA;
              end
            end
          end
          tlc_pkg::TLC_ACK_ADDR: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (is_read) begin
                sda_oe_out <= ~rd_data[7];
                tx_byte <= {rd_data[6:0], 1'b0};
                state <= tlc_pkg::TLC_RDATA;
              end else begin
                sda_oe_out <= 1'b0;
                state <= tlc_pkg::TLC_CMD;
              end
            end
          end
          tlc_pkg::TLC_ACK_CMD: begin
            if (scl_fall) begin
              sda_oe_out <= 1'b0;
              state <= tlc_pkg::TLC_WDATA;
            end
          end
          tlc_pkg::TLC_ACK_WDATA: begin
            if (scl_fall) begin
              sda_oe_out <= 1'b0;
              state <= tlc_pkg::TLC_WDATA;
            end
          end
          tlc_pkg::TLC_RDATA: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == `TLC_BITS_PER_BYTE) begin
                sda_oe_out <= 1'b0;
                state <= tlc_pkg::TLC_RACK;
              end else begin
                sda_oe_out <= ~tx_byte[7];
                tx_byte <= {tx_byte[6:0], 1'b0};
              end
            end
          end
          tlc_pkg::TLC_RACK: begin
            if (scl_rise) begin
              nacked <= sda_in;
              bit_cnt <= 4'h0;
            end else if (scl_fall) begin
              if (nacked) begin
                state <= tlc_pkg::TLC_IDLE;
              end else begin
                sda_oe_out <= ~rd_data[7];
                tx_byte <= {rd_data[6:0], 1'b0};
                state <= tlc_pkg::TLC_RDATA;
              end
            end
          end
          default: begin
            state <= tlc_pkg::TLC_IDLE;
          end
        endcase
      end
    end
  end

  // loop registers refuse writes silently once locked
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      loop_pacing_control_one <= `TLC_RST_LOOP_ONE;
      loop_pacing_control_two <= `TLC_RST_LOOP_TWO;
    end else if (wr_pulse && !locked) begin
      if (pointer == `TLC_OFS_LOOP_ONE) begin
        loop_pacing_control_one <= wr_data;
      end else if (pointer == `TLC_OFS_LOOP_TWO) begin
        loop_pacing_control_two <= wr_data;
      end
    end
  end

  // only reset clears the lock, so it models power cycling
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      main_configuration_one <= `TLC_RST_CONFIG;
    end else begin
      if (power_good_in) begin
        main_configuration_one[`TLC_CFG_READY] <= 1'b1;
      end
      if (wr_pulse && pointer == `TLC_OFS_CONFIG) begin
        main_configuration_one[`TLC_CFG_FULL_SPEED] <= wr_data[`TLC_CFG_FULL_SPEED];
        main_configuration_one[`TLC_CFG_SPINUP_DIS] <= wr_data[`TLC_CFG_SPINUP_DIS];
        if (!locked) begin
          main_configuration_one[`TLC_CFG_LOCK] <= wr_data[`TLC_CFG_LOCK];
          main_configuration_one[`TLC_CFG_START] <= wr_data[`TLC_CFG_START];
          main_configuration_one[`TLC_CFG_POWER_DISP] <= wr_data[`TLC_CFG_POWER_DISP];
          main_configuration_one[`TLC_CFG_TIMEOUT_DIS] <= wr_data[`TLC_CFG_TIMEOUT_DIS];
          main_configuration_one[`TLC_CFG_SUPPLY_5V] <= wr_data[`TLC_CFG_SUPPLY_5V];
        end
      end
    end
  end

  assign monitor_start_bit_out = main_configuration_one[`TLC_CFG_START];
  assign all_fans_full_speed_out = main_configuration_one[`TLC_CFG_FULL_SPEED];
  assign spinup_pulse_disable_out = main_configuration_one[`TLC_CFG_SPINUP_DIS];
  assign bus_timeout_disable_out = main_configuration_one[`TLC_CFG_TIMEOUT_DIS];
  assign supply_5v_scale_out = main_configuration_one[`TLC_CFG_SUPPLY_5V];
  assign power_display_out = main_configuration_one[`TLC_CFG_POWER_DISP];
  assign config_locked_out = locked;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mon_cnt <= 32'h0000_0000;
      mon_tick <= 1'b0;
    end else if (mon_cnt >= 32'(MON_CYCLE_CLKS - 1)) begin
      mon_cnt <= 32'h0000_0000;
      mon_tick <= 1'b1;
    end else begin
      mon_cnt <= mon_cnt + 32'h0000_0001;
      mon_tick <= 1'b0;
    end
  end

  assign pacing_code[0] = loop_pacing_control_two[`TLC_L2_R1_HI:`TLC_L2_R1_LO];
  assign pacing_code[1] = loop_pacing_control_two[`TLC_L2_LOC_HI:`TLC_L2_LOC_LO];
  assign pacing_code[2] = {loop_pacing_control_one[`TLC_L1_R2_MSB],
    loop_pacing_control_two[`TLC_L2_R2_HI:`TLC_L2_R2_LO]};
  assign dyn_enable[0] = loop_pacing_control_one[`TLC_L1_R1_EN];
  assign dyn_enable[1] = loop_pacing_control_one[`TLC_L1_LOC_EN];
  assign dyn_enable[2] = loop_pacing_control_one[`TLC_L1_R2_EN];

  // counts saturate at the longest interval so a stalled loop cannot wrap
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_pace
    logic [10:0] cyc_cnt;
    logic active;
    assign active = dyn_enable[ch] & main_configuration_one[`TLC_CFG_START];
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        cyc_cnt <= 11'h000;
      end else if (!active || adjust_done_in[ch]) begin
        cyc_cnt <= 11'h000;
      end else if (mon_tick && cyc_cnt < `TLC_CYC_MAX) begin
        cyc_cnt <= cyc_cnt + 11'h001;
      end
    end
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        decrease_ok_out[ch] <= 1'b0;
        increase_ok_out[ch] <= 1'b0;
      end else begin
        decrease_ok_out[ch] <= active && !adjust_done_in[ch]
          && cyc_cnt >= (`TLC_DEC_BASE << pacing_code[ch]);
        increase_ok_out[ch] <= active && !adjust_done_in[ch]
          && cyc_cnt >= (`TLC_INC_BASE << pacing_code[ch]);
      end
    end
  end
endmodule

//--- tlc_defs.svh
// offsets, bit positions, reset values and timing constants for the thermal loop config registers
`ifndef TLC_DEFS_SVH
`define TLC_DEFS_SVH

`define TLC_OFS_LOOP_ONE 8'h36
`define TLC_OFS_LOOP_TWO 8'h37
`define TLC_OFS_CONFIG 8'h40

`define TLC_RST_LOOP_ONE 8'h00
`define TLC_RST_LOOP_TWO 8'h00
`define TLC_RST_CONFIG 8'h00
`define TLC_READ_UNMAPPED 8'h00

`define TLC_L1_R2_MSB 0
`define TLC_L1_R1_EN 5
`define TLC_L1_LOC_EN 6
`define TLC_L1_R2_EN 7
`define TLC_L2_R1_LO 0
`define TLC_L2_R1_HI 2
`define TLC_L2_LOC_LO 3
`define TLC_L2_LOC_HI 5
`define TLC_L2_R2_LO 6
`define TLC_L2_R2_HI 7

`define TLC_CFG_START 0
`define TLC_CFG_LOCK 1
`define TLC_CFG_READY 2
`define TLC_CFG_FULL_SPEED 3
`define TLC_CFG_POWER_DISP 4
`define TLC_CFG_SPINUP_DIS 5
`define TLC_CFG_TIMEOUT_DIS 6
`define TLC_CFG_SUPPLY_5V 7

`define TLC_DEC_BASE 11'h004
`define TLC_INC_BASE 11'h008
`define TLC_CYC_MAX 11'h400

`define TLC_CLK_PERIOD_NS 50
`define TLC_MON_CYCLE_MS 125
`define TLC_BUS_TIMEOUT_MS 25
`define TLC_NS_PER_MS 1000000

`define TLC_BITS_PER_BYTE 4'h8
`define TLC_SLAVE_ADDR 7'h2c

`endif

//--- tlc_pkg.sv
// types shared by the thermal loop config register block
package tlc_pkg;
  typedef enum logic [8:0] {
    TLC_IDLE      = 9'b0_0000_0001,
    TLC_ADDR      = 9'b0_0000_0010,
    TLC_ACK_ADDR  = 9'b0_0000_0100,
    TLC_CMD       = 9'b0_0000_1000,
    TLC_ACK_CMD   = 9'b0_0001_0000,
    TLC_WDATA     = 9'b0_0010_0000,
    TLC_ACK_WDATA = 9'b0_0100_0000,
    TLC_RDATA     = 9'b0_1000_0000,
    TLC_RACK      = 9'b1_0000_0000
  } tlc_state_t;
endpackage

//--- tlc_host.sv
// two-wire bus host model that reaches the register block
`timescale 1ns/1ps
module tlc_host #(
  parameter logic [6:0] ADDR = 7'h2c
) (
  input wire logic core_clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  logic [6:0] addr = ADDR;
  logic ack;
  logic addr_ack;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  // start and repeated start alike: data falls while clock is high
  task automatic go();
    sda_low_out = 1'b0;
    tk(2);
    scl_out = 1'b1;
    tk(2);
    sda_low_out = 1'b1;
    tk(2);
    scl_out = 1'b0;
    tk(2);
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    tk(2);
    scl_out = 1'b1;
    tk(2);
    sda_low_out = 1'b0;
    tk(4);
  endtask
  // data only moves in the low phase; sampled mid-way through the high phase
  task automatic bit_cyc(input logic b, output logic s);
    sda_low_out = !b;
    tk(3);
    scl_out = 1'b1;
    tk(2);
    s = sda_in;
    tk(2);
    scl_out = 1'b0;
    tk(1);
  endtask
  task automatic tx(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(v[i], s);
    bit_cyc(1'b1, ack);
  endtask
  // last byte is always answered with a not-acknowledge
  task automatic rx(output logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, v[i]);
    bit_cyc(1'b1, ack);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    go();
    tx({addr, 1'b0});
    addr_ack = ack;
    tx(ofs);
    tx(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    go();
    tx({addr, 1'b0});
    tx(ofs);
    go();
    tx({addr, 1'b1});
    rx(d);
    stop();
  endtask
endmodule

//--- tlc_chk.sv
// port assertions for the thermal loop config registers
`timescale 1ns/1ps
module tlc_chk #(
  parameter int CHANNELS = 3
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [CHANNELS-1:0] adjust_done_in,
  input wire logic [CHANNELS-1:0] decrease_ok_out,
  input wire logic [CHANNELS-1:0] increase_ok_out,
  input wire logic monitor_start_bit_out,
  input wire logic bus_timeout_disable_out,
  input wire logic supply_5v_scale_out,
  input wire logic power_display_out,
  input wire logic config_locked_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_start_off;
    !monitor_start_bit_out [*3];
  endsequence
  sequence s_locked;
    config_locked_out ##1 config_locked_out;
  endsequence
  a_lock_stays_set: assert property (config_locked_out |=> config_locked_out)
    else $error("lock bit dropped");
  a_start_frozen: assert property (s_locked |-> $stable(monitor_start_bit_out))
    else $error("start bit moved while locked");
  a_locked_fields: assert property (s_locked |-> $stable(supply_5v_scale_out)
    && $stable(bus_timeout_disable_out) && $stable(power_display_out))
    else $error("lockable field moved while locked");
  a_idle_no_ok: assert property (s_start_off |-> decrease_ok_out == '0 && increase_ok_out == '0)
    else $error("pacing ready while stopped");
  a_ok_needs_start: assert property ((|decrease_ok_out) |-> $past(monitor_start_bit_out, 2))
    else $error("pacing ready without start");
  a_done_clears_ok: assert property (|adjust_done_in |=>
    ((decrease_ok_out | increase_ok_out) & $past(adjust_done_in)) == '0)
    else $error("pacing ready right after adjustment");
  a_inc_after_dec: assert property ((increase_ok_out & ~decrease_ok_out) == '0)
    else $error("increase ready before decrease");
  a_sda_move_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data line moved while clock high");
  a_drain_only: assert property (sda_out == 1'b0)
    else $error("data line driven high");
endmodule
bind tlc_regs tlc_chk #(.CHANNELS(CHANNELS)) chk (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_out(sda_oe_out), .adjust_done_in(adjust_done_in),
  .decrease_ok_out(decrease_ok_out), .increase_ok_out(increase_ok_out),
  .monitor_start_bit_out(monitor_start_bit_out),
  .bus_timeout_disable_out(bus_timeout_disable_out),
  .supply_5v_scale_out(supply_5v_scale_out), .power_display_out(power_display_out),
  .config_locked_out(config_locked_out)
);

//--- tb.sv
// self-checking bench for the thermal loop config registers
`timescale 1ns/1ps
`include "tlc_defs.svh"
module tb;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic power_good_in = 1'b0;
  logic [2:0] adjust_done_in = 3'b000;
  logic scl, sda_low, sda_out, sda_oe_out, sda;
  logic [2:0] dec_ok, inc_ok;
  logic start_o, all_fans_full_speed_o, spin_o, tmo_o, vsel_o, pwr_o, lock_o;
  logic [7:0] rv, outs;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int at[6] = '{58, 85, 165, 325, 1258, 1285};
  logic [7:0] exp_ok[6] = '{8'h00, 8'h01, 8'h0b, 8'h1b, 8'h1b, 8'h1f};
  // pull-up on the data line; either side may pull it low
  assign sda = !(sda_low || (sda_oe_out && !sda_out));
  assign outs = {vsel_o, tmo_o, spin_o, pwr_o, all_fans_full_speed_o, 1'b0, lock_o, start_o};
  tlc_regs #(.MON_CYCLE_CLKS(20), .TIMEOUT_CLKS(200)) uut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .power_good_in(power_good_in),
    .adjust_done_in(adjust_done_in), .decrease_ok_out(dec_ok), .increase_ok_out(inc_ok),
    .monitor_start_bit_out(start_o), .all_fans_full_speed_out(all_fans_full_speed_o),
    .spinup_pulse_disable_out(spin_o), .bus_timeout_disable_out(tmo_o),
    .supply_5v_scale_out(vsel_o), .power_display_out(pwr_o), .config_locked_out(lock_o)
  );
  tlc_host host (.core_clk_in(core_clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
  initial forever #25 core_clk_in = !core_clk_in;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_cmp(input logic [7:0] ofs, input logic [7:0] exp);
    host.rd(ofs, rv);
    cmp(rv, exp);
  endtask
  // the whole sequence needs about 10k cycles
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    repeat (10) @(negedge core_clk_in);
    rst_in = 1'b0;
    host.tk(2);
    rd_cmp(`TLC_OFS_CONFIG, `TLC_RST_CONFIG);
    power_good_in = 1'b1;
    rd_cmp(`TLC_OFS_CONFIG, 8'h04);
    rd_cmp(`TLC_OFS_LOOP_TWO, `TLC_RST_LOOP_TWO);
    host.wr(`TLC_OFS_LOOP_TWO, 8'ha5);
    cmp_flag(host.addr_ack, 1'b0);
    rd_cmp(`TLC_OFS_LOOP_TWO, 8'ha5);
    host.wr(`TLC_OFS_LOOP_TWO, 8'h08);
    host.wr(`TLC_OFS_LOOP_ONE, 8'he1);
    rd_cmp(`TLC_OFS_LOOP_ONE, 8'he1);
    host.wr(`TLC_OFS_CONFIG, 8'hf9);
    rd_cmp(`TLC_OFS_CONFIG, 8'hfd);
    cmp(outs, 8'hf9);
    adjust_done_in = 3'b111;
    host.tk(1);
    adjust_done_in = 3'b000;
    for (int i = 0; i < 6; i++) begin
      host.tk(at[i] - (i > 0 ? at[i - 1] : 0));
      cmp({2'b00, inc_ok, dec_ok}, exp_ok[i]);
    end
    // restarting one channel must leave the other two counting
    adjust_done_in = 3'b001;
    host.tk(1);
    adjust_done_in = 3'b000;
    host.tk(1);
    cmp({2'b00, inc_ok, dec_ok}, 8'h16);
    host.wr(`TLC_OFS_LOOP_ONE, 8'h61);
    host.tk(4);
    cmp_flag(dec_ok[2], 1'b0);
    host.wr(`TLC_OFS_CONFIG, 8'hf8);
    host.tk(4);
    cmp({2'b00, inc_ok, dec_ok}, 8'h00);
    rd_cmp(`TLC_OFS_LOOP_TWO, 8'h08);
    host.wr(`TLC_OFS_CONFIG, 8'hfb);
    rd_cmp(`TLC_OFS_CONFIG, 8'hff);
    host.wr(`TLC_OFS_CONFIG, 8'h00);
    rd_cmp(`TLC_OFS_CONFIG, 8'hd7);
    cmp(outs, 8'hd3);
    host.wr(`TLC_OFS_LOOP_TWO, 8'hff);
    rd_cmp(`TLC_OFS_LOOP_TWO, 8'h08);
    host.wr(`TLC_OFS_LOOP_ONE, 8'h00);
    rd_cmp(`TLC_OFS_LOOP_ONE, 8'h61);
    rd_cmp(8'h41, `TLC_READ_UNMAPPED);
    host.addr = 7'h2d;
    host.wr(`TLC_OFS_CONFIG, 8'h08);
    cmp_flag(host.addr_ack, 1'b1);
    host.addr = `TLC_SLAVE_ADDR;
    rd_cmp(`TLC_OFS_CONFIG, 8'hd7);
    // only a power cycle may clear the lock
    rst_in = 1'b1;
    host.tk(3);
    rst_in = 1'b0;
    host.tk(2);
    rd_cmp(`TLC_OFS_CONFIG, 8'h04);
    cmp(outs, 8'h00);
    // a clock held low past the limit drops the frame unless timeout is off
    host.go();
    host.tx({host.addr, 1'b0});
    cmp_flag(host.ack, 1'b0);
    host.tk(250);
    host.tx(`TLC_OFS_CONFIG);
    cmp_flag(host.ack, 1'b1);
    host.stop();
    host.wr(`TLC_OFS_CONFIG, 8'h40);
    host.go();
    host.tx({host.addr, 1'b0});
    host.tk(250);
    host.tx(`TLC_OFS_CONFIG);
    cmp_flag(host.ack, 1'b0);
    host.tx(8'h41);
    host.stop();
    rd_cmp(`TLC_OFS_CONFIG, 8'h45);
    cmp(outs, 8'h41);
    complete_run();
  end
endmodule
